/* jtag_active_config_control.sv */
// JTAG control of the active configuration controllers, user clock switch and boot address.
// Assumes rstn is power-on reset; JTAG and configuration pins are asynchronous to clk.
//
// Functional notes
// - Disengage instruction idles the active controller
// - Mode pins pick serial or parallel controller
// - Disengage ignored in passive schemes
// - User mode after programming re-engages controllers
// - Serial re-engages on TAP reset or engage
// - Parallel re-engages only on engage instruction or user mode after programming
// - Engage re-engages and starts active reconfiguration
// - Passive engage pulses restart; restart pin masked
// - Oscillator default; user clock needs running oscillator
// - Oscillator stops in user mode unless needed
// - Only power-on reset or the disable instruction reverts clock source
// - User clock latch kept until disable or reset
// - Boot instruction gives 22-bit shift and update
// - Capture copies update register into shift register
// - Flash address gets two zero bits appended
// - Remote update limits boot address to factory image
// - Boot address survives reconfiguration, lost on power-off
`include "jtag_ctl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module jtag_active_config_control #(
  parameter int IR_W   = `IR_WIDTH,
  parameter int BOOT_W = `BOOT_ADDR_WIDTH
) (
  // Clock and power-on reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // JTAG pins
  input  wire logic          tck,
  input  wire logic          tms,
  input  wire logic          tdi,
  output logic               tdo,
  output logic               tdoOe,
  // Configuration pins
  input  wire logic [3:0]    modeSelectPins,
  input  wire logic          userClockPin,
  input  wire logic          configRestartN,
  // Configuration core
  input  wire logic          userMode,
  output logic               serialEngaged,
  output logic               parallelEngaged,
  output logic               reconfigStart,
  output logic               oscEnable,
  output logic               clockSourceUser,
  output logic [BOOT_W+1:0]  flashStartAddr,
  output logic               bootAddrFactoryOnly,
  output logic               remoteUpdateEnable,
  output logic               errorDetectEnable
);
  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  logic rstSync1;
  logic rstN;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1 <= 1'b0;
      rstN     <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstN     <= rstSync1;
    end
  end

  logic [8:0] pinsSync;
  logic       tckSync;
  logic       tmsSync;
  logic       tdiSync;
  logic       userClkSync;
  logic       restartNSync;
  logic [3:0] modeSync;

  pin_sync #(.WIDTH(9)) u_pin_sync (
    .clk    (clk),
    .rstN   (rstN),
    .pinIn  ({modeSelectPins, configRestartN, userClockPin, tdi, tms, tck}),
    .pinOut (pinsSync)
  );

  assign tckSync      = pinsSync[0];
  assign tmsSync      = pinsSync[1];
  assign tdiSync      = pinsSync[2];
  assign userClkSync  = pinsSync[3];
  assign restartNSync = pinsSync[4];
  assign modeSync     = pinsSync[8:5];

  logic tckLast;
  logic userClkLast;
  logic tckRise;
  logic tckFall;
  logic userClkRise;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tckLast     <= 1'b0;
      userClkLast <= 1'b0;
    end else begin
      tckLast     <= tckSync;
      userClkLast <= userClkSync;
    end
  end

  assign tckRise     = tckSync & ~tckLast;
  assign tckFall     = ~tckSync & tckLast;
  assign userClkRise = userClkSync & ~userClkLast;

  // ----------------------------------------
  // Scheme decode
  // ----------------------------------------
  function automatic jtag_ctl_pkg::scheme_t decodeScheme(input logic [3:0] pins);
    case (pins)
      `MODE_FAST_PASSIVE:    decodeScheme = jtag_ctl_pkg::SCHEME_FAST_PASSIVE;
      `MODE_ACTIVE_SERIAL:   decodeScheme = jtag_ctl_pkg::SCHEME_ACTIVE_SERIAL;
      `MODE_ACTIVE_PARALLEL: decodeScheme = jtag_ctl_pkg::SCHEME_ACTIVE_PARALLEL;
      default:               decodeScheme = jtag_ctl_pkg::SCHEME_PASSIVE_SERIAL;
    endcase
  endfunction

  jtag_ctl_pkg::scheme_t scheme;
  logic                  schemeSerial;
  logic                  schemeParallel;

  assign scheme         = decodeScheme(modeSync);
  assign schemeSerial   = (scheme == jtag_ctl_pkg::SCHEME_ACTIVE_SERIAL);
  assign schemeParallel = (scheme == jtag_ctl_pkg::SCHEME_ACTIVE_PARALLEL);

  // ----------------------------------------
  // TAP and instruction register
  // ----------------------------------------
  jtag_ctl_pkg::tap_state_t tapState;

  tap_state_machine u_tap (
    .clk     (clk),
    .rstN    (rstN),
    .tckRise (tckRise),
    .tmsIn   (tmsSync),
    .state   (tapState)
  );

  logic [IR_W-1:0] irShift;
  logic [IR_W-1:0] instr;
  logic            tapReset;
  logic            irUpdate;

  assign tapReset = tckRise & tmsSync & (tapState == jtag_ctl_pkg::TAP_SELECT_IR);
  assign irUpdate = tckRise & (tapState == jtag_ctl_pkg::TAP_UPDATE_IR);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irShift <= IR_W'(`IR_CAPTURE);
      instr   <= IR_W'(`INSTR_BYPASS);
    end else if (tckRise) begin
      case (tapState)
        jtag_ctl_pkg::TAP_RESET:      instr   <= IR_W'(`INSTR_BYPASS);
        jtag_ctl_pkg::TAP_CAPTURE_IR: irShift <= IR_W'(`IR_CAPTURE);
        jtag_ctl_pkg::TAP_SHIFT_IR:   irShift <= {tdiSync, irShift[IR_W-1:1]};
        jtag_ctl_pkg::TAP_UPDATE_IR:  instr   <= irShift;
        default:                      instr   <= instr;
      endcase
    end
  end

  // Instruction takes effect as it enters the instruction register
  logic doDisengage;
  logic doEngage;
  logic doClkOn;
  logic doClkOff;
  logic doProgram;
  logic doPulse;

  assign doDisengage = irUpdate & (irShift == IR_W'(`INSTR_DISENGAGE));
  assign doEngage    = irUpdate & (irShift == IR_W'(`INSTR_ENGAGE));
  assign doClkOn     = irUpdate & (irShift == IR_W'(`INSTR_USER_CLK_ON));
  assign doClkOff    = irUpdate & (irShift == IR_W'(`INSTR_USER_CLK_OFF));
  assign doProgram   = irUpdate & (irShift == IR_W'(`INSTR_PROGRAM));
  assign doPulse     = irUpdate & (irShift == IR_W'(`INSTR_PULSE_RESTART));

  // ----------------------------------------
  // Active controller engagement
  // ----------------------------------------
  logic programPending;
  logic userModeLast;
  logic userModeRise;

  assign userModeRise = userMode & ~userModeLast;

  // Armed by the programming instruction, cleared when user mode is reached
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      programPending <= 1'b0;
      userModeLast   <= 1'b0;
    end else begin
      userModeLast <= userMode;
      if (doProgram) begin
        programPending <= 1'b1;
      end else if (userModeRise) begin
        programPending <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      serialEngaged <= 1'b1;
    end else if (doEngage && schemeSerial) begin
      serialEngaged <= 1'b1;
    end else if (programPending && userModeRise) begin
      serialEngaged <= 1'b1;
    end else if (tapReset) begin
      serialEngaged <= 1'b1;
    end else if (doDisengage && schemeSerial) begin
      serialEngaged <= 1'b0;
    end
  end

  // Restart pin and TAP reset leave the parallel controller alone
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      parallelEngaged <= 1'b1;
    end else if (doEngage && schemeParallel) begin
      parallelEngaged <= 1'b1;
    end else if (programPending && userModeRise) begin
      parallelEngaged <= 1'b1;
    end else if (doDisengage && schemeParallel) begin
      parallelEngaged <= 1'b0;
    end
  end
  // Passive schemes fall through both branches untouched

  // ----------------------------------------
  // Reconfiguration and oscillator
  // ----------------------------------------
  logic restartMasked;
  logic restartLast;
  logic restartFall;
  logic reconfigEvent;

  // Restart pin is ignored while engage is the current instruction
  assign restartMasked = (instr == IR_W'(`INSTR_ENGAGE)) ? 1'b1 : restartNSync;
  assign restartFall   = restartLast & ~restartMasked;
  assign reconfigEvent = doEngage | doPulse | restartFall;

  logic reconfigActive;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      // Synchroniser leaves reset low; matching it avoids a false restart edge
      restartLast    <= 1'b0;
      reconfigStart  <= 1'b0;
      reconfigActive <= 1'b0;
    end else begin
      restartLast   <= restartMasked;
      reconfigStart <= reconfigEvent;
      if (reconfigEvent) begin
        reconfigActive <= 1'b1;
      end else if (userModeRise) begin
        reconfigActive <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      oscEnable <= 1'b1;
    end else begin
      oscEnable <= ~userMode | reconfigActive | remoteUpdateEnable | errorDetectEnable;
    end
  end

  // ----------------------------------------
  // Clock source latch
  // ----------------------------------------
  logic       userClockLatch;
  logic [3:0] tailCount;

  // Only power-on reset or the disable instruction clears the latch
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      userClockLatch <= 1'b0;
    end else if (doClkOff) begin
      userClockLatch <= 1'b0;
    end else if (doClkOn && oscEnable) begin
      userClockLatch <= 1'b1;
    end
  end

  // Switch back only after the user clock has run its tail
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      clockSourceUser <= 1'b0;
      tailCount       <= 4'h0;
    end else if (userClockLatch) begin
      clockSourceUser <= 1'b1;
      tailCount       <= 4'h0;
    end else if (clockSourceUser && userClkRise) begin
      if (tailCount == `USER_CLK_TAIL_EDGES - 4'h1) begin
        clockSourceUser <= 1'b0;
        tailCount       <= 4'h0;
      end else begin
        tailCount <= tailCount + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Boot address data register
  // ----------------------------------------
  logic [BOOT_W-1:0] bootShift;
  logic [BOOT_W-1:0] bootUpdate;
  logic              bypassBit;
  logic              bootSelected;

  assign bootSelected = (instr == IR_W'(`INSTR_BOOT_ADDRESS));

  // Only power-on reset and the boot-address update state touch the update register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      bootShift  <= '0;
      bootUpdate <= BOOT_W'(`BOOT_ADDR_DEFAULT);
      bypassBit  <= 1'b0;
    end else if (tckRise) begin
      case (tapState)
        jtag_ctl_pkg::TAP_CAPTURE_DR: begin
          bypassBit <= 1'b0;
          if (bootSelected) begin
            bootShift <= bootUpdate;
          end
        end
        jtag_ctl_pkg::TAP_SHIFT_DR: begin
          bypassBit <= tdiSync;
          if (bootSelected) begin
            bootShift <= {tdiSync, bootShift[BOOT_W-1:1]};
          end
        end
        jtag_ctl_pkg::TAP_UPDATE_DR: begin
          if (bootSelected) begin
            bootUpdate <= bootShift;
          end
        end
        default: begin
          bypassBit <= bypassBit;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      flashStartAddr      <= '0;
      bootAddrFactoryOnly <= 1'b0;
    end else begin
      flashStartAddr      <= {bootUpdate, 2'b00};
      bootAddrFactoryOnly <= remoteUpdateEnable;
    end
  end

  // TDO changes on the falling test clock
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tdo   <= 1'b0;
      tdoOe <= 1'b0;
    end else if (tckFall) begin
      tdoOe <= (tapState == jtag_ctl_pkg::TAP_SHIFT_DR) || (tapState == jtag_ctl_pkg::TAP_SHIFT_IR);
      if (tapState == jtag_ctl_pkg::TAP_SHIFT_IR) begin
        tdo <= irShift[0];
      end else if (bootSelected) begin
        tdo <= bootShift[0];
      end else begin
        tdo <= bypassBit;
      end
    end
  end

  // ----------------------------------------
  // APB register slave
  // ----------------------------------------
  logic setup;
  logic mapped;

  assign setup  = psel & ~penable;
  assign mapped = (paddr == `ADDR_CTRL) || (paddr == `ADDR_STATUS) || (paddr == `ADDR_BOOT);

  // Zero wait: answer ready in the first access cycle
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite) begin
        case (paddr)
          `ADDR_CTRL:   prdata <= {30'h00000000, errorDetectEnable, remoteUpdateEnable};
          `ADDR_STATUS: prdata <= {16'h0000, instr, scheme, oscEnable, clockSourceUser,
                                   parallelEngaged, serialEngaged};
          `ADDR_BOOT:   prdata <= {{(32-BOOT_W){1'b0}}, bootUpdate};
          default:      prdata <= 32'h00000000;
        endcase
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      remoteUpdateEnable <= 1'b0;
      errorDetectEnable  <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == `ADDR_CTRL) begin
      remoteUpdateEnable <= pwdata[`CTRL_REMOTE_BIT];
      errorDetectEnable  <= pwdata[`CTRL_ERRDET_BIT];
    end
  end
endmodule
`default_nettype wire

/* jtag_ctl_cfg.svh */
// Constants of the JTAG active configuration control block.
// Assumes nothing; included by the top module and the testbench.
`ifndef JTAG_CTL_CFG_SVH
`define JTAG_CTL_CFG_SVH

// ----------------------------------------
// Instruction register
// ----------------------------------------
`define IR_WIDTH              10
`define IR_CAPTURE            10'h001
`define INSTR_BYPASS          10'h3FF
`define INSTR_DISENGAGE       10'h2C0
`define INSTR_ENGAGE          10'h2B0
`define INSTR_USER_CLK_ON     10'h1E0
`define INSTR_USER_CLK_OFF    10'h1E1
`define INSTR_BOOT_ADDRESS    10'h1E2
`define INSTR_PROGRAM         10'h002
`define INSTR_STARTUP         10'h003
`define INSTR_PULSE_RESTART   10'h001

// ----------------------------------------
// Mode select codes
// ----------------------------------------
`define MODE_PASSIVE_SERIAL   4'h0
`define MODE_FAST_PASSIVE     4'h1
`define MODE_ACTIVE_SERIAL    4'h2
`define MODE_ACTIVE_PARALLEL  4'h3

// ----------------------------------------
// Boot address and user clock
// ----------------------------------------
`define BOOT_ADDR_WIDTH       22
`define BOOT_ADDR_DEFAULT     22'h000000
`define USER_CLK_TAIL_EDGES   4'hA

// ----------------------------------------
// Register map
// ----------------------------------------
`define ADDR_CTRL             12'h000
`define ADDR_STATUS           12'h004
`define ADDR_BOOT             12'h008
`define CTRL_REMOTE_BIT       0
`define CTRL_ERRDET_BIT       1

`endif

/* jtag_ctl_pkg.sv */
// Types shared by the JTAG active configuration control block.
// Assumes the constants header is on the include path.
package jtag_ctl_pkg;

  // ----------------------------------------
  // TAP controller states
  // ----------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET      = 4'b0000,
    TAP_IDLE       = 4'b0001,
    TAP_SELECT_DR  = 4'b0010,
    TAP_CAPTURE_DR = 4'b0011,
    TAP_SHIFT_DR   = 4'b0100,
    TAP_EXIT1_DR   = 4'b0101,
    TAP_PAUSE_DR   = 4'b0110,
    TAP_EXIT2_DR   = 4'b0111,
    TAP_UPDATE_DR  = 4'b1000,
    TAP_SELECT_IR  = 4'b1001,
    TAP_CAPTURE_IR = 4'b1010,
    TAP_SHIFT_IR   = 4'b1011,
    TAP_EXIT1_IR   = 4'b1100,
    TAP_PAUSE_IR   = 4'b1101,
    TAP_EXIT2_IR   = 4'b1110,
    TAP_UPDATE_IR  = 4'b1111
  } tap_state_t;

  // ----------------------------------------
  // Configuration schemes
  // ----------------------------------------
  typedef enum logic [1:0] {
    SCHEME_PASSIVE_SERIAL = 2'b00,
    SCHEME_FAST_PASSIVE   = 2'b01,
    SCHEME_ACTIVE_SERIAL  = 2'b10,
    SCHEME_ACTIVE_PARALLEL = 2'b11
  } scheme_t;

endpackage

/* pin_sync.sv */
// Two-stage synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk; reset is the synchronised copy.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // Pins
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1 <= '0;
      pinOut <= '0;
    end else begin
      stage1 <= pinIn;
      pinOut <= stage1;
    end
  end
endmodule
`default_nettype wire

/* tap_state_machine.sv */
// TAP controller state machine, stepped once per detected test clock rise.
// Assumes tmsIn is already synchronised and tckRise is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module tap_state_machine (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rstN,
  // Test access
  input  wire logic                tckRise,
  input  wire logic                tmsIn,
  output jtag_ctl_pkg::tap_state_t state
);
  jtag_ctl_pkg::tap_state_t next_state;

  always_comb begin
    case (state)
      jtag_ctl_pkg::TAP_RESET:      next_state = tmsIn ? jtag_ctl_pkg::TAP_RESET      : jtag_ctl_pkg::TAP_IDLE;
      jtag_ctl_pkg::TAP_IDLE:       next_state = tmsIn ? jtag_ctl_pkg::TAP_SELECT_DR  : jtag_ctl_pkg::TAP_IDLE;
      jtag_ctl_pkg::TAP_SELECT_DR:  next_state = tmsIn ? jtag_ctl_pkg::TAP_SELECT_IR  : jtag_ctl_pkg::TAP_CAPTURE_DR;
      jtag_ctl_pkg::TAP_CAPTURE_DR: next_state = tmsIn ? jtag_ctl_pkg::TAP_EXIT1_DR   : jtag_ctl_pkg::TAP_SHIFT_DR;
      jtag_ctl_pkg::TAP_SHIFT_DR:   next_state = tmsIn ? jtag_ctl_pkg::TAP_EXIT1_DR   : jtag_ctl_pkg::TAP_SHIFT_DR;
      jtag_ctl_pkg::TAP_EXIT1_DR:   next_state = tmsIn ? jtag_ctl_pkg::TAP_UPDATE_DR  : jtag_ctl_pkg::TAP_PAUSE_DR;
      jtag_ctl_pkg::TAP_PAUSE_DR:   next_state = tmsIn ? jtag_ctl_pkg::TAP_EXIT2_DR   : jtag_ctl_pkg::TAP_PAUSE_DR;
      jtag_ctl_pkg::TAP_EXIT2_DR:   next_state = tmsIn ? jtag_ctl_pkg::TAP_UPDATE_DR  : jtag_ctl_pkg::TAP_SHIFT_DR;
      jtag_ctl_pkg::TAP_UPDATE_DR:  next_state = tmsIn ? jtag_ctl_pkg::TAP_SELECT_DR  : jtag_ctl_pkg::TAP_IDLE;
      jtag_ctl_pkg::TAP_SELECT_IR:  next_state = tmsIn ? jtag_ctl_pkg::TAP_RESET      : jtag_ctl_pkg::TAP_CAPTURE_IR;
      jtag_ctl_pkg::TAP_CAPTURE_IR: next_state = tmsIn ? jtag_ctl_pkg::TAP_EXIT1_IR   : jtag_ctl_pkg::TAP_SHIFT_IR;
      jtag_ctl_pkg::TAP_SHIFT_IR:   next_state = tmsIn ? jtag_ctl_pkg::TAP_EXIT1_IR   : jtag_ctl_pkg::TAP_SHIFT_IR;
      jtag_ctl_pkg::TAP_EXIT1_IR:   next_state = tmsIn ? jtag_ctl_pkg::TAP_UPDATE_IR  : jtag_ctl_pkg::TAP_PAUSE_IR;
      jtag_ctl_pkg::TAP_PAUSE_IR:   next_state = tmsIn ? jtag_ctl_pkg::TAP_EXIT2_IR   : jtag_ctl_pkg::TAP_PAUSE_IR;
      jtag_ctl_pkg::TAP_EXIT2_IR:   next_state = tmsIn ? jtag_ctl_pkg::TAP_UPDATE_IR  : jtag_ctl_pkg::TAP_SHIFT_IR;
      jtag_ctl_pkg::TAP_UPDATE_IR:  next_state = tmsIn ? jtag_ctl_pkg::TAP_SELECT_DR  : jtag_ctl_pkg::TAP_IDLE;
      default:                      next_state = jtag_ctl_pkg::TAP_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state <= jtag_ctl_pkg::TAP_RESET;
    end else if (tckRise) begin
      state <= next_state;
    end
  end
endmodule
`default_nettype wire

/* jtag_active_config_control_props.sv */
// Checker on the top module ports.
// Assumes it is bound into the design top.
`timescale 1ns/1ps
`default_nettype none
module jtag_active_config_control_props #(
  parameter int BOOT_W = 22
) (
  // Clock and bus
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Configuration core
  input wire logic              userMode,
  input wire logic              reconfigStart,
  input wire logic              oscEnable,
  input wire logic              clockSourceUser,
  input wire logic [BOOT_W+1:0] flashStartAddr,
  input wire logic              bootAddrFactoryOnly,
  input wire logic              remoteUpdateEnable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_setup;
    psel && !penable;
  endsequence
  property p_ready; s_setup |=> pready ##1 !pready; endproperty
  a_ready: assert property (p_ready) else $error("ready not one cycle after setup");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside access");
  property p_align;
    psel && penable && pready && !pwrite && paddr == 12'h008 |->
      prdata == 32'(flashStartAddr[BOOT_W+1:2]) && flashStartAddr[1:0] == 2'h0;
  endproperty
  a_align: assert property (p_align) else $error("flash address low bits set");
  property p_factory; bootAddrFactoryOnly == $past(remoteUpdateEnable); endproperty
  a_factory: assert property (p_factory) else $error("factory-only flag wrong");
  property p_osc; !userMode |=> oscEnable; endproperty
  a_osc: assert property (p_osc) else $error("oscillator off before user mode");
  property p_pulse; reconfigStart |=> !reconfigStart; endproperty
  a_pulse: assert property (p_pulse) else $error("restart pulse too long");
  property p_usrclk; $rose(clockSourceUser) |-> $past(oscEnable); endproperty
  a_usrclk: assert property (p_usrclk) else $error("user clock without oscillator");
endmodule
bind jtag_active_config_control jtag_active_config_control_props #(.BOOT_W(BOOT_W)) props_i (
  .clk, .rstn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .userMode, .reconfigStart,
  .oscEnable, .clockSourceUser, .flashStartAddr, .bootAddrFactoryOnly, .remoteUpdateEnable);
`default_nettype wire

/* jtag_host_model.sv */
// JTAG host model on the test pins.
// Assumes the device samples tck with its own clock.
`timescale 1ns/1ps
`default_nettype none
module jtag_host_model (
  // Test pins
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  input  wire logic tdo
);
  initial tck = 1'b0;
  initial tms = 1'b1;
  initial tdi = 1'b0;
  // Clock stands low between frames
  task automatic step(input logic m, input logic d, output logic r);
    tms <= m;
    tdi <= d;
    #62.5 tck <= 1'b1;
    r = tdo;
    #62.5 tck <= 1'b0;
  endtask
  // From idle to idle; n bits LSB first
  task automatic scan(input logic ir, input int n, input logic [21:0] d, output logic [21:0] q);
    logic r;
    step(1'b1, 1'b0, r);
    if (ir)
      step(1'b1, 1'b0, r);
    step(1'b0, 1'b0, r);
    step(1'b0, 1'b0, r);
    for (int i = 0; i < n; i++)
      step(i == n - 1, d[i], q[i]);
    step(1'b1, 1'b0, r);
    step(1'b0, 1'b0, r);
    // No stale bit on a released line
    tdi <= ~tdi;
  endtask
endmodule
`default_nettype wire

/* jtag_active_config_control_tb.sv */
// Testbench: APB and JTAG sequences with expected values.
// Assumes host model and checker are compiled first.
`include "jtag_ctl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module jtag_active_config_control_tb;
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, userMode = 1'b0;
  logic        userClockPin = 1'b0, configRestartN = 1'b1, e, b, pready, pslverr, tck, tms, tdi, tdo;
  logic        tdoOe, serialEngaged, parallelEngaged, reconfigStart, oscEnable, clockSourceUser;
  logic        bootAddrFactoryOnly, remoteUpdateEnable, errorDetectEnable;
  logic [3:0]  modeSelectPins = 4'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [23:0] flashStartAddr;
  logic [21:0] v;
  int          n_mismatch = 0, samples_checked = 0, nRs = 0, nOe = 0;
  logic        oeLast = 1'b0;
  jtag_active_config_control jtag_active_config_control_i (.clk, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tck, .tms, .tdi, .tdo, .tdoOe, .modeSelectPins,
    .userClockPin, .configRestartN, .userMode, .serialEngaged, .parallelEngaged, .reconfigStart,
    .oscEnable, .clockSourceUser, .flashStartAddr, .bootAddrFactoryOnly, .remoteUpdateEnable,
    .errorDetectEnable);
  jtag_host_model jtag_host_model_i (.tck, .tms, .tdi, .tdo);
  // Restart pulses and shift windows seen on the pins
  always @(posedge clk) begin
    nRs += reconfigStart;
    nOe += tdoOe & ~oeLast;
    oeLast <= tdoOe;
  end
  initial begin
    forever #5 clk = ~clk;
  end
  // Slow enough for the sampling clock
  always begin
    repeat (6) @(posedge clk);
    userClockPin <= ~userClockPin;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    @(posedge clk);
    while (pready !== 1'b1 && k < 40) begin
      @(posedge clk);
      k++;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(k == 40), 32'h0);
    if (k == 40)
      print_verdict();
  endtask
  task automatic ir(input logic [9:0] c);
    jtag_host_model_i.scan(1'b1, 10, 22'(c), v);
    repeat (4) @(posedge clk);
  endtask
  task automatic tapReset();
    repeat (3) jtag_host_model_i.step(1'b1, 1'b0, b);
    jtag_host_model_i.step(1'b0, 1'b0, b);
    repeat (4) @(posedge clk);
  endtask
  task automatic restart();
    @(posedge clk);
    configRestartN <= 1'b0;
    repeat (4) @(posedge clk);
    configRestartN <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  function automatic logic [31:0] eng();
    return 32'({serialEngaged, parallelEngaged});
  endfunction
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'({eng(), oscEnable, clockSourceUser, flashStartAddr}), 32'h0E000000);
    jtag_host_model_i.step(1'b0, 1'b0, b);
    apb(1'b1, `ADDR_CTRL, 32'h3);
    apb(1'b0, `ADDR_CTRL, 32'h0);
    chk(q, 32'h3);
    chk(32'(bootAddrFactoryOnly), 32'h1);
    apb(1'b0, 12'h0FC, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, `ADDR_CTRL, 32'h0);
    modeSelectPins <= `MODE_ACTIVE_SERIAL;
    ir(`INSTR_DISENGAGE);
    chk(eng(), 32'h1);
    tapReset();
    chk(eng(), 32'h3);
    modeSelectPins <= `MODE_ACTIVE_PARALLEL;
    ir(`INSTR_DISENGAGE);
    restart();
    chk(eng(), 32'h2);
    ir(`INSTR_ENGAGE);
    chk(eng(), 32'h3);
    modeSelectPins <= `MODE_PASSIVE_SERIAL;
    ir(`INSTR_DISENGAGE);
    chk(eng(), 32'h3);
    ir(`INSTR_BOOT_ADDRESS);
    jtag_host_model_i.scan(1'b0, 22, 22'h2AB3C5, v);
    restart();
    chk(32'(flashStartAddr), 32'hAACF14);
    apb(1'b0, `ADDR_BOOT, 32'h0);
    chk(q, 32'h2AB3C5);
    jtag_host_model_i.scan(1'b0, 22, 22'h0, v);
    chk(32'(v), 32'h2AB3C5);
    @(posedge clk);
    ir(`INSTR_USER_CLK_ON);
    chk(32'(clockSourceUser), 32'h1);
    ir(`INSTR_BYPASS);
    tapReset();
    restart();
    chk(32'(clockSourceUser), 32'h1);
    ir(`INSTR_USER_CLK_OFF);
    repeat (200) @(posedge clk);
    chk(32'(clockSourceUser), 32'h0);
    modeSelectPins <= `MODE_ACTIVE_SERIAL;
    ir(`INSTR_DISENGAGE);
    ir(`INSTR_PROGRAM);
    ir(`INSTR_STARTUP);
    userMode <= 1'b1;
    repeat (4) @(posedge clk);
    chk(eng(), 32'h3);
    chk(32'(oscEnable), 32'h0);
    ir(`INSTR_USER_CLK_ON);
    chk(32'(clockSourceUser), 32'h0);
    tapReset();
    chk(32'(nRs), 32'h4);
    chk(32'(nOe), 32'hE);
    print_verdict();
  end
endmodule
`default_nettype wire
